/* File: dv/fidar_regs_asserts.sv */
// Purpose: Concurrent checks on the flash identity and address registers
// Assumes: Only top-level ports are seen; clock enable is high while reads are taken
// Notes:   Bound to every instance of the register block
`timescale 1ns/1ps
`default_nettype none
module fidar_regs_asserts
    import fidar_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        clockEnable,
    // Wishbone slave side
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Sector walk
    input wire logic        xferStart,
    input wire logic        xferStep,
    input wire logic        xferBusy,
    input wire logic        xferDone,
    input wire logic [3:0]  bufferSectorSelect,
    input wire logic        bootBufferRamSel,
    input wire logic        dataBufferRam1Sel,
    input wire logic        bufferSectorBit
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // A new request taken, and a read of one word
    sequence reqTaken;
        clockEnable && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence readTaken(a);
        reqTaken and (!wb_we_i && wb_adr_i[17:2] == a);
    endsequence
    // Fixed words answer one edge after the read is taken
    property constRead(a, v);
        readTaken(a) |=> wb_ack_o && wb_dat_o == {16'h0, v};
    endproperty
    data_cap_a: assert property (constRead(IDX_DATA_CAP, 16'h0400))
        else $error("data buffer size read wrong");
    boot_cap_a: assert property (constRead(IDX_BOOT_CAP, 16'h0200))
        else $error("boot buffer size read wrong");
    buf_count_a: assert property (constRead(IDX_BUF_COUNT, 16'h0201))
        else $error("buffer count read wrong");
    cell_cell_type_code_a: assert property (constRead(IDX_CELL_CELL_TYPE_CODE, 16'h0000))
        else $error("cell technology read wrong");
    ack_pulse_a: assert property (reqTaken |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one edge after request");
    ram_sel_a: assert property (bootBufferRamSel == !bufferSectorSelect[3])
        else $error("boot or data buffer choice wrong");
    sector_bit_a: assert property (dataBufferRam1Sel == bufferSectorSelect[2]
        && bufferSectorBit == bufferSectorSelect[0]) else $error("buffer or sector bit wrong");
    step_incr_a: assert property ((xferBusy && xferStep && clockEnable ##1 xferBusy)
        |-> bufferSectorSelect == $past(bufferSectorSelect) + 4'h1) else $error("no increment");
    start_busy_a: assert property (clockEnable && xferStart && !xferBusy |=> xferBusy)
        else $error("walk did not start");
    done_pulse_a: assert property (xferDone |-> !xferBusy ##1 !xferDone)
        else $error("done pulse too long or busy with done");
endmodule

bind fidar_regs fidar_regs_asserts i_fidar_regs_asserts (.clock(clock), .reset(reset),
    .clockEnable(clockEnable), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .xferStart(xferStart),
    .xferStep(xferStep), .xferBusy(xferBusy), .xferDone(xferDone),
    .bufferSectorSelect(bufferSectorSelect), .bootBufferRamSel(bootBufferRamSel),
    .dataBufferRam1Sel(dataBufferRam1Sel), .bufferSectorBit(bufferSectorBit));
`default_nettype wire

/* File: dv/fidar_regs_tb.sv */
// Purpose: Self-checking bench for the flash identity and address registers
// Assumes: Straps held steady from time zero; clock enable stays high except while t_freeze drives it low
// Notes:   Byte address is four times the register index
`timescale 1ns/1ps
`default_nettype none
module fidar_regs_tb;
    import fidar_pkg::*;
    logic        clock, reset, clockEnable, cyc, stb, we, dmx, dual, boot, xStart, xStep;
    logic [17:0] adr;
    logic [3:0]  sel;
    logic [31:0] datI, datO;
    logic [1:0]  supply;
    logic        ack, busy, done;
    logic [8:0]  blkIdx;
    logic [5:0]  pgIdx, cpIdx;
    logic [3:0]  bsSel;
    logic [8:0]  cbIdx;
    logic        cSec, aSec;
    int          n_mismatch, num_checks, cycles;
    logic [15:0] cI [4] = '{IDX_DATA_CAP, IDX_BOOT_CAP, IDX_BUF_COUNT, IDX_CELL_CELL_TYPE_CODE};
    logic [15:0] aI [5] = '{IDX_SRC_BLOCK, IDX_COPY_BLOCK, IDX_COPY_PGSEC, IDX_START_PGSEC,
                            IDX_BUF_SELECT};

    fidar_regs i_fidar_regs (.clock(clock), .reset(reset), .clockEnable(clockEnable),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .supplyClass(supply),
        .demuxBus(dmx), .dualDiePackage(dual), .bootTop(boot), .arrayBlockIndex(blkIdx),
        .copyDestBlockIndex(cbIdx), .copyDestPageIndex(cpIdx), .copyDestSectorIndex(cSec),
        .arrayPageIndex(pgIdx), .arraySectorIndex(aSec), .xferStart(xStart), .xferStep(xStep),
        .xferBusy(busy), .xferDone(done), .bufferSectorSelect(bsSel),
        .bootBufferRamSel(), .dataBufferRam1Sel(), .bufferSectorBit());

    // Clock generator
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Hang guard, well above the hundred and fifty or so cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            wrap_up;
        end
    end

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task chk1(input string nm, input logic e, input logic g);
        chk(nm, {15'h0, e}, {15'h0, g});
    endtask

    // One classic cycle; held until ack is seen at an edge, then released
    task wb(input logic w, input logic [15:0] ix, input logic [15:0] d, input logic [3:0] s,
            output logic [15:0] q);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {ix, 2'b00}; sel <= s; datI <= {16'h0, d};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) chk1("ack", 1'b1, ack);
        q = datO[15:0];
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clock);
    endtask

    task wr(input logic [15:0] ix, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] q;
        wb(1'b1, ix, d, s, q);
    endtask

    task rdc(input logic [15:0] ix, input logic [15:0] e);
        logic [15:0] q;
        wb(1'b0, ix, 16'h0, 4'h3, q);
        chk($sformatf("reg %h", ix), e, q);
    endtask

    task t_consts;
        foreach (cI[i]) wr(cI[i], 16'hffff, 4'h3);
        rdc(IDX_DATA_CAP, 16'h0400);
        rdc(IDX_BOOT_CAP, 16'h0200);
        rdc(IDX_BUF_COUNT, 16'h0201);
        rdc(IDX_CELL_CELL_TYPE_CODE, 16'h0000);
        $display("t_consts finished");
    endtask

    task t_id;
        wr(IDX_PART_DESC, 16'h0000, 4'h3);
        wr(IDX_SPARE_TWO, 16'hffff, 4'h3);
        rdc(IDX_PART_DESC, 16'h0115);
        rdc(IDX_REV_SLOT, 16'h0000);
        rdc(IDX_SPARE_TWO, 16'h0000);
        rdc(IDX_SPARE_SEVEN, 16'h0000);
        $display("t_id finished");
    endtask

    task t_addr;
        rdc(IDX_SRC_BLOCK, 16'h0000);
        rdc(IDX_COPY_BLOCK, 16'h0000);
        rdc(IDX_COPY_PGSEC, 16'h0000);
        rdc(IDX_START_PGSEC, 16'h0000);
        rdc(IDX_BUF_SELECT, 16'h0000);
        foreach (aI[i]) wr(aI[i], 16'hffff, 4'h3);
        rdc(IDX_COPY_BLOCK, 16'h01ff);
        rdc(IDX_COPY_PGSEC, 16'h00fd);
        rdc(IDX_START_PGSEC, 16'h00fd);
        rdc(IDX_BUF_SELECT, 16'h0f03);
        chk("page out", 16'h003f, {10'h0, pgIdx});
        chk("copy page out", 16'h003f, {10'h0, cpIdx});
        chk("copy block out", 16'h01ff, {7'h0, cbIdx});
        chk1("copy sector out", 1'b1, cSec);
        chk1("sector out", 1'b1, aSec);
        wr(IDX_SRC_BLOCK, 16'h0000, 4'h2);
        rdc(IDX_SRC_BLOCK, 16'h00ff);
        chk("block out", 16'h00ff, {7'h0, blkIdx});
        $display("t_addr finished");
    endtask

    // Low clock enable must swallow a start pulse
    task t_freeze;
        clockEnable <= 1'b0;
        xStart <= 1'b1;
        repeat (2) @(posedge clock);
        xStart <= 1'b0;
        clockEnable <= 1'b1;
        @(negedge clock);
        chk1("frozen busy", 1'b0, busy);
        $display("t_freeze finished");
    endtask

    // Second reset in mid-run; straps are captured again three edges later
    task t_rst;
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        chk("block after reset", 16'h0000, {7'h0, blkIdx});
        chk1("busy after reset", 1'b0, busy);
        repeat (3) @(posedge clock);
        rdc(IDX_PART_DESC, 16'h0115);
        $display("t_rst finished");
    endtask

    // Sector walk from b over c sectors, count zero meaning two
    task walk(input logic [3:0] b, input logic [1:0] c);
        int n;
        n = (c == 2'h0) ? 2 : int'(c);
        wr(IDX_BUF_SELECT, {4'h0, b, 6'h0, c}, 4'h3);
        xStart <= 1'b1;
        @(posedge clock);
        xStart <= 1'b0;
        for (int k = 0; k < n; k++) begin
            @(negedge clock);
            chk1("busy", 1'b1, busy);
            chk("select", {12'h0, b + k[3:0]}, {12'h0, bsSel});
            @(posedge clock);
            xStep <= 1'b1;
            @(posedge clock);
            xStep <= 1'b0;
        end
        @(negedge clock);
        chk1("done", 1'b1, done);
        chk1("busy", 1'b0, busy);
        @(negedge clock);
        chk1("done", 1'b0, done);
        $display("walk from %h finished", b);
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        reset = 1'b1; clockEnable = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0;
        sel = '0; datI = '0; supply = 2'h1; dmx = 1'b1; dual = 1'b0; boot = 1'b1;
        xStart = 1'b0; xStep = 1'b0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
        t_consts;
        t_id;
        t_addr;
        t_freeze;
        t_rst;
        walk(4'h8, 2'h0);
        walk(4'hf, 2'h2);
        walk(4'h5, 2'h3);
        wrap_up;
    end
endmodule
`default_nettype wire

/* File: src/fidar_pkg.sv */
// Purpose: Constants and types for the flash identity and address registers
// Assumes: Word indices are scaled by four to form Wishbone byte addresses
// Notes:   Strap values feed the identity word; capacity words are fixed
package fidar_pkg;

    // Register indices, byte address is four times the index
    localparam logic [15:0] IDX_PART_DESC   = 16'hf001;
    localparam logic [15:0] IDX_REV_SLOT    = 16'hf002;
    localparam logic [15:0] IDX_DATA_CAP    = 16'hf003;
    localparam logic [15:0] IDX_BOOT_CAP    = 16'hf004;
    localparam logic [15:0] IDX_BUF_COUNT   = 16'hf005;
    localparam logic [15:0] IDX_CELL_CELL_TYPE_CODE   = 16'hf006;
    localparam logic [15:0] IDX_SRC_BLOCK   = 16'hf100;
    localparam logic [15:0] IDX_SPARE_TWO   = 16'hf101;
    localparam logic [15:0] IDX_COPY_BLOCK  = 16'hf102;
    localparam logic [15:0] IDX_COPY_PGSEC  = 16'hf103;
    localparam logic [15:0] IDX_SPARE_FIVE  = 16'hf104;
    localparam logic [15:0] IDX_SPARE_SEVEN = 16'hf106;
    localparam logic [15:0] IDX_START_PGSEC = 16'hf107;
    localparam logic [15:0] IDX_BUF_SELECT  = 16'hf200;

    // Fixed capability words
    localparam logic [15:0] DATA_CAP_WORDS  = 16'h0400;
    localparam logic [15:0] BOOT_CAP_WORDS  = 16'h0200;
    localparam logic [15:0] BUF_COUNT_WORD  = 16'h0201;
    localparam logic [15:0] CELL_SINGLE     = 16'h0000;
    localparam logic [3:0]  DENSITY_256MB   = 4'h1;
    localparam logic [1:0]  SUPPLY_HIGH     = 2'h1;

    // Field positions
    localparam int unsigned ID_DEMUX_BIT    = 2;
    localparam int unsigned ID_DUAL_BIT     = 3;
    localparam int unsigned ID_DENS_LSB     = 4;
    localparam int unsigned ID_BOOT_BIT     = 8;
    localparam int unsigned PAGE_LSB        = 2;
    localparam int unsigned BSA_LSB         = 8;
    localparam int unsigned BSA_BOOT_BIT    = 3;
    localparam int unsigned BSA_DRAM_BIT    = 2;

    // Reset values and counts
    localparam logic [8:0]  BLOCK_RST       = 9'h000;
    localparam logic [5:0]  PAGE_RST        = 6'h00;
    localparam logic [3:0]  BSA_RST         = 4'h0;
    localparam logic [1:0]  BSC_RST         = 2'h0;
    localparam logic [1:0]  BSC_ZERO_COUNT  = 2'h2;
    localparam logic [1:0]  STRAP_SETTLE    = 2'h3; // Two sync edges, then one capture edge

    // Transfer sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_MOVE = 2'b10
    } fidar_seq_type;

    // Whole state of the register block
    typedef struct packed {
        logic          ack;
        logic [31:0]   rdData;
        logic [8:0]    blk;
        logic [8:0]    copyBlk;
        logic [5:0]    copyPage;
        logic          copySec;
        logic [5:0]    page;
        logic          sec;
        logic [3:0]    buffer_sector_select;
        logic [1:0]    buffer_sector_count;
        logic [4:0]    strapMeta;
        logic [4:0]    strapSync;
        logic [4:0]    strapHeld;
        logic [1:0]    strapCnt;
        fidar_seq_type seq;
        logic [3:0]    curBsa;
        logic [1:0]    left;
        logic          done;
    } fidar_state_type;

endpackage

/* File: src/fidar_regs.sv */
// Purpose: Identity, capability and array address registers on Wishbone
// Assumes: Classic Wishbone, 32-bit data, registers in low 16 bits
// Notes:   A small sequencer walks the buffer sector select per transfer
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module fidar_regs
    import fidar_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        clockEnable,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Identity straps from pins
    input  wire logic [1:0]  supplyClass,
    input  wire logic        demuxBus,
    input  wire logic        dualDiePackage,
    input  wire logic        bootTop,
    // Array addresses to the flash core
    output logic      [8:0]  arrayBlockIndex,
    output logic      [8:0]  copyDestBlockIndex,
    output logic      [5:0]  copyDestPageIndex,
    output logic             copyDestSectorIndex,
    output logic      [5:0]  arrayPageIndex,
    output logic             arraySectorIndex,
    // Buffer transfer handshake with the core
    input  wire logic        xferStart,
    input  wire logic        xferStep,
    output logic             xferBusy,
    output logic             xferDone,
    output logic      [3:0]  bufferSectorSelect,
    output logic             bootBufferRamSel,
    output logic             dataBufferRam1Sel,
    output logic             bufferSectorBit
);

    fidar_state_type st_r;
    fidar_state_type st_nxt;

    // Sector count for a transfer, zero stands for two
    function automatic logic [1:0] sectorCount(input logic [1:0] buffer_sector_count);
        sectorCount = (buffer_sector_count == BSC_RST) ? BSC_ZERO_COUNT : buffer_sector_count;
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] laneMerge(
        input logic [15:0] oldVal,
        input logic [15:0] newVal,
        input logic [1:0]  sel
    );
        laneMerge[7:0]  = sel[0] ? newVal[7:0]  : oldVal[7:0];
        laneMerge[15:8] = sel[1] ? newVal[15:8] : oldVal[15:8];
    endfunction

    // Identity word from captured straps
    function automatic logic [15:0] idWord(input logic [4:0] strap);
        idWord = 16'h0000;
        // Reserved supply codes are never reported
        idWord[1:0] = strap[1] ? SUPPLY_HIGH : strap[1:0];
        idWord[ID_DEMUX_BIT] = strap[2];
        idWord[ID_DUAL_BIT]  = strap[3];
        idWord[ID_DENS_LSB +: 4] = DENSITY_256MB;
        idWord[ID_BOOT_BIT]  = strap[4];
    endfunction

    logic [15:0] index;
    logic        request;
    logic        doWrite;
    logic [15:0] wrWord;
    logic [15:0] mrg;
    logic [15:0] readWord;

    // Request decode; word index comes from the upper address bits
    assign index   = wb_adr_i[17:2];
    assign request = wb_cyc_i & wb_stb_i & ~st_r.ack;
    assign doWrite = request & wb_we_i;
    assign wrWord  = wb_dat_i[15:0];

    // Read multiplexer; unmapped and reserved slots read zero
    always_comb begin
        readWord = 16'h0000;
        if (index == IDX_PART_DESC) begin
            readWord = idWord(st_r.strapHeld);
        end else if (index == IDX_DATA_CAP) begin
            readWord = DATA_CAP_WORDS;
        end else if (index == IDX_BOOT_CAP) begin
            readWord = BOOT_CAP_WORDS;
        end else if (index == IDX_BUF_COUNT) begin
            readWord = BUF_COUNT_WORD;
        end else if (index == IDX_CELL_CELL_TYPE_CODE) begin
            readWord = CELL_SINGLE;
        end else if (index == IDX_SRC_BLOCK) begin
            readWord = {7'h00, st_r.blk};
        end else if (index == IDX_COPY_BLOCK) begin
            readWord = {7'h00, st_r.copyBlk};
        end else if (index == IDX_COPY_PGSEC) begin
            readWord = {8'h00, st_r.copyPage, 1'b0, st_r.copySec};
        end else if (index == IDX_START_PGSEC) begin
            readWord = {8'h00, st_r.page, 1'b0, st_r.sec};
        end else if (index == IDX_BUF_SELECT) begin
            readWord = {4'h0, st_r.buffer_sector_select, 6'h00, st_r.buffer_sector_count};
        end else if (index == IDX_REV_SLOT || index == IDX_SPARE_TWO ||
                     (index >= IDX_SPARE_FIVE && index <= IDX_SPARE_SEVEN)) begin
            readWord = 16'h0000;
        end
    end

    // Next-state logic: bus, straps and transfer sequencer
    always_comb begin
        st_nxt = st_r;
        mrg    = 16'h0000;
        st_nxt.ack  = request; // Ack one cycle after the strobe
        st_nxt.done = 1'b0;
        if (request) begin
            st_nxt.rdData = wb_we_i ? 32'h0000_0000 : {16'h0000, readWord};
        end

        // Straps pass two flops, then are held once settled
        st_nxt.strapMeta = {bootTop, dualDiePackage, demuxBus, supplyClass};
        st_nxt.strapSync = st_r.strapMeta;
        if (st_r.strapCnt != STRAP_SETTLE) begin
            st_nxt.strapCnt  = st_r.strapCnt + 2'h1;
            st_nxt.strapHeld = st_r.strapSync;
        end

        // Writes; read-only and reserved slots drop the data
        if (doWrite) begin
            if (index == IDX_SRC_BLOCK) begin
                mrg = laneMerge({7'h00, st_r.blk}, wrWord, wb_sel_i[1:0]);
                st_nxt.blk = mrg[8:0];
            end else if (index == IDX_COPY_BLOCK) begin
                mrg = laneMerge({7'h00, st_r.copyBlk}, wrWord, wb_sel_i[1:0]);
                st_nxt.copyBlk = mrg[8:0];
            end else if (index == IDX_COPY_PGSEC) begin
                mrg = laneMerge({8'h00, st_r.copyPage, 1'b0, st_r.copySec},
                                wrWord, wb_sel_i[1:0]);
                st_nxt.copyPage = mrg[PAGE_LSB +: 6];
                st_nxt.copySec  = mrg[0];
            end else if (index == IDX_START_PGSEC) begin
                mrg = laneMerge({8'h00, st_r.page, 1'b0, st_r.sec},
                                wrWord, wb_sel_i[1:0]);
                st_nxt.page = mrg[PAGE_LSB +: 6];
                st_nxt.sec  = mrg[0];
            end else if (index == IDX_BUF_SELECT) begin
                mrg = laneMerge({4'h0, st_r.buffer_sector_select, 6'h00, st_r.buffer_sector_count},
                                wrWord, wb_sel_i[1:0]);
                st_nxt.buffer_sector_select = mrg[BSA_LSB +: 4];
                st_nxt.buffer_sector_count = mrg[1:0];
            end
        end

        // Sector walk; the running copy leaves the register untouched
        case (st_r.seq)
            SEQ_IDLE: begin
                if (xferStart) begin
                    st_nxt.seq    = SEQ_MOVE;
                    st_nxt.curBsa = st_r.buffer_sector_select;
                    st_nxt.left   = sectorCount(st_r.buffer_sector_count);
                end
            end
            SEQ_MOVE: begin
                if (xferStep) begin
                    if (st_r.left == 2'h1) begin
                        st_nxt.seq  = SEQ_IDLE;
                        st_nxt.done = 1'b1;
                    end else begin
                        st_nxt.left   = st_r.left - 2'h1;
                        st_nxt.curBsa = st_r.curBsa + 4'h1;
                    end
                end
            end
            default: begin
                st_nxt.seq = SEQ_IDLE;
            end
        endcase
    end

    // State register; a low clock enable freezes everything
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_r.ack       <= 1'b0;
            st_r.rdData    <= 32'h0000_0000;
            st_r.blk       <= BLOCK_RST;
            st_r.copyBlk   <= BLOCK_RST;
            st_r.copyPage  <= PAGE_RST;
            st_r.copySec   <= 1'b0;
            st_r.page      <= PAGE_RST;
            st_r.sec       <= 1'b0;
            st_r.buffer_sector_select       <= BSA_RST;
            st_r.buffer_sector_count       <= BSC_RST;
            st_r.strapMeta <= 5'h00;
            st_r.strapSync <= 5'h00;
            st_r.strapHeld <= 5'h00;
            st_r.strapCnt  <= 2'h0;
            st_r.seq       <= SEQ_IDLE;
            st_r.curBsa    <= BSA_RST;
            st_r.left      <= 2'h0;
            st_r.done      <= 1'b0;
        end else if (clockEnable) begin
            st_r <= st_nxt;
        end
    end

    // Bus answers
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdData;

    // Address fields to the core
    assign arrayBlockIndex     = st_r.blk;
    assign copyDestBlockIndex  = st_r.copyBlk;
    assign copyDestPageIndex   = st_r.copyPage;
    assign copyDestSectorIndex = st_r.copySec;
    assign arrayPageIndex      = st_r.page;
    assign arraySectorIndex    = st_r.sec;

    // Buffer selection follows the running copy while busy
    assign xferBusy           = (st_r.seq == SEQ_MOVE);
    assign xferDone           = st_r.done;
    assign bufferSectorSelect = xferBusy ? st_r.curBsa : st_r.buffer_sector_select;
    assign bootBufferRamSel   = ~bufferSectorSelect[BSA_BOOT_BIT];
    assign dataBufferRam1Sel  = bufferSectorSelect[BSA_DRAM_BIT];
    assign bufferSectorBit    = bufferSectorSelect[0];

endmodule

`default_nettype wire
